//--- clock_divider.sv
`timescale 1ns/10ps
// Produces a one-cycle enable every div_i cycles of its input enable
module clock_divider
    import reset_mode_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic src_en_i,
    input wire logic [DIV_W:0] div_i,
    output logic tick_o
);
    logic [DIV_W:0] count;
    wire last_count = (count >= div_i - (DIV_W+1)'(1));
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            count <= '0;
            tick_o <= 1'b0;
        end
        else
        begin
            tick_o <= src_en_i && last_count;
            if (src_en_i)
                count <= last_count ? '0 : count + (DIV_W+1)'(1);
        end
    end
endmodule

//--- reset_mode_pkg.sv
package reset_mode_pkg;
    localparam int MAIN_OSC_DIV = 64;
    localparam int SEC_OSC_DIV = 2;
    localparam int DIV_W = 6;
    localparam logic [1:0] SYS_CLK_MAIN = 2'h0;
    localparam logic [1:0] SYS_CLK_SECONDARY = 2'h1;
    localparam logic [7:0] PORT_DIR_RESET = 8'h00;
    localparam logic [6:0] FOURTH_DISPLAY_RESET = 7'h7f;
    localparam logic [7:0] FIFTH_DISPLAY_RESET = 8'hff;
    localparam logic [7:0] OPEN_DRAIN_ONLY_MASK = 8'hc0;
    localparam logic [7:0] SERIAL_SHARED_MASK = 8'h07;
    localparam int FIRST_IRQ_BIT = 7;
    localparam int SECOND_IRQ_BIT = 6;
    localparam logic [15:0] USER_RESET_VECTOR = 16'hfffe;
    localparam logic [15:0] SELF_CHECK_RESET_VECTOR = 16'hffee;
    typedef enum logic [1:0] {
        MODE_SINGLE_CHIP = 2'b01,
        MODE_SELF_CHECK = 2'b10
    } op_mode_e;
endpackage

//--- reset_mode_select.sv
`timescale 1ns/10ps
// Functional notes
// - Default internal clock is main oscillator / 64
// - Secondary oscillator selected divides by two
// - First port all inputs at reset
// - Third port all inputs at reset
// - Fourth port lines default to display drivers
// - Fifth port lines default to frontplane drivers
// - Second port input-only, feeds key wakeup, pull-ups
// - Third port bits 0-2 serial, open-drain capable
// - Third port bit 6 open-drain only output
// - Third port bit 7 open-drain only output
// - Low reset pin forces known startup state
// - Mode chosen only at reset rising edge
// - Both interrupt pins captured to decide mode
// - Mode latched, only external reset changes it
// - While reset low, pins as single-chip
// - Self-check needs test voltage on one pin
// - Single-chip mode keeps bus internal
// - Self-check fetches vector from self-check ROM
// - Self-check unlocks privileged control bits
module reset_mode_select
    import reset_mode_pkg::*;
(
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // External reset pin and mode straps
    input wire logic ext_reset_n_i,
    input wire logic first_irq_test_voltage_i,
    input wire logic second_irq_supply_level_i,
    // Oscillator selection
    input wire logic main_osc_en_i,
    input wire logic secondary_osc_en_i,
    input wire logic [1:0] system_clock_select_field_i,
    // Port configuration from software
    input wire logic [7:0] first_port_dir_i,
    input wire logic [7:0] third_port_dir_i,
    input wire logic [7:0] third_port_out_i,
    input wire logic [7:0] third_port_open_drain_i,
    input wire logic [7:0] second_port_pullup_i,
    input wire logic [6:0] fourth_port_gpo_sel_i,
    input wire logic [7:0] fifth_port_gpo_sel_i,
    input wire logic [7:0] second_port_lines_i,
    input wire logic privileged_write_i,
    // Outputs
    output logic internal_op_tick_o,
    output logic device_reset_o,
    output logic self_check_mode_o,
    output logic single_chip_mode_o,
    output logic external_bus_enable_o,
    output logic [15:0] reset_vector_addr_o,
    output logic privileged_access_o,
    output logic [7:0] first_port_dir_o,
    output logic [7:0] third_port_oe_o,
    output logic [7:0] third_port_out_o,
    output logic [7:0] key_wakeup_input_o,
    output logic [7:0] second_port_pullup_o,
    output logic [6:0] fourth_port_display_o,
    output logic [7:0] fifth_port_display_o
);
    logic reset_sync1;
    logic reset_sync2;
    logic reset_prev;
    op_mode_e mode;
    logic [7:0] first_dir;
    logic [7:0] third_dir;
    logic [6:0] fourth_disp;
    logic [7:0] fifth_disp;
    logic [7:0] second_pullup;

    // Two-stage synchroniser on the external reset pin
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            reset_sync1 <= 1'b0;
            reset_sync2 <= 1'b0;
            reset_prev <= 1'b0;
        end
        else
        begin
            reset_sync1 <= ext_reset_n_i;
            reset_sync2 <= reset_sync1;
            reset_prev <= reset_sync2;
        end
    end

    wire pin_in_reset = !reset_sync2;
    wire in_reset = rst_i || pin_in_reset;
    wire reset_rise = reset_sync2 && !reset_prev;
    wire self_check_request = first_irq_test_voltage_i
        && second_irq_supply_level_i;
    wire op_mode_e next_mode = op_mode_e'(self_check_request
        ? MODE_SELF_CHECK : MODE_SINGLE_CHIP);

    // Mode latch: reset loads single-chip, only the reset rising edge loads the strap mode
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i || pin_in_reset)
            mode <= MODE_SINGLE_CHIP;
        else if (reset_rise)
            mode <= next_mode;
    end

    wire self_check = (mode == MODE_SELF_CHECK) && !pin_in_reset;

    // Clock source selection and division
    wire use_secondary = system_clock_select_field_i == SYS_CLK_SECONDARY;
    wire div_src_en = use_secondary ? secondary_osc_en_i : main_osc_en_i;
    wire [DIV_W:0] div_value = use_secondary ? (DIV_W+1)'(SEC_OSC_DIV)
        : (DIV_W+1)'(MAIN_OSC_DIV);

    clock_divider u_divider (
        .core_clk_i(core_clk_i),
        .rst_i(in_reset),
        .src_en_i(div_src_en),
        .div_i(div_value),
        .tick_o(internal_op_tick_o)
    );

    // Port configuration registers with reset defaults
    always_ff @(posedge core_clk_i)
    begin
        if (in_reset)
        begin
            first_dir <= PORT_DIR_RESET;
            third_dir <= PORT_DIR_RESET;
            fourth_disp <= FOURTH_DISPLAY_RESET;
            fifth_disp <= FIFTH_DISPLAY_RESET;
            second_pullup <= 8'h00;
        end
        else
        begin
            first_dir <= first_port_dir_i;
            third_dir <= third_port_dir_i;
            fourth_disp <= ~fourth_port_gpo_sel_i;
            fifth_disp <= ~fifth_port_gpo_sel_i;
            second_pullup <= second_port_pullup_i;
        end
    end

    // Third port drive: open-drain forced on interrupt-shared bits
    wire [7:0] od_mask = third_port_open_drain_i | OPEN_DRAIN_ONLY_MASK;
    wire [7:0] third_drive_hi = third_port_out_i & ~od_mask;
    wire [7:0] third_oe = third_dir
        & (third_drive_hi | ~third_port_out_i);

    always_ff @(posedge core_clk_i)
    begin
        if (in_reset)
        begin
            third_port_oe_o <= 8'h00;
            third_port_out_o <= 8'h00;
            key_wakeup_input_o <= 8'h00;
            reset_vector_addr_o <= USER_RESET_VECTOR;
            privileged_access_o <= 1'b0;
        end
        else
        begin
            third_port_oe_o <= third_oe;
            third_port_out_o <= third_port_out_i;
            key_wakeup_input_o <= second_port_lines_i;
            reset_vector_addr_o <= self_check ? SELF_CHECK_RESET_VECTOR
                : USER_RESET_VECTOR;
            privileged_access_o <= self_check
                && privileged_write_i;
        end
    end

    assign device_reset_o = in_reset;
    assign self_check_mode_o = self_check;
    assign single_chip_mode_o = !self_check;
    assign external_bus_enable_o = 1'b0;
    assign first_port_dir_o = first_dir;
    assign second_port_pullup_o = second_pullup;
    assign fourth_port_display_o = fourth_disp;
    assign fifth_port_display_o = fifth_disp;

    // Source enables counted between divider ticks for the ratio check
    logic [1:0] prev_select;
    logic [DIV_W:0] tick_gap;
    logic gap_valid;
    wire select_changed = system_clock_select_field_i != prev_select;
    wire [DIV_W:0] ratio_expected =
        (system_clock_select_field_i == SYS_CLK_SECONDARY)
        ? (DIV_W+1)'(SEC_OSC_DIV) : (DIV_W+1)'(MAIN_OSC_DIV);

    always_ff @(posedge core_clk_i)
    begin
        prev_select <= system_clock_select_field_i;
        if (in_reset)
        begin
            tick_gap <= '0;
            gap_valid <= 1'b1;
        end
        else if (select_changed)
        begin
            tick_gap <= '0;
            gap_valid <= 1'b0;
        end
        else if (internal_op_tick_o)
        begin
            tick_gap <= (DIV_W+1)'(div_src_en);
            gap_valid <= 1'b1;
        end
        else if (div_src_en)
        begin
            tick_gap <= tick_gap + (DIV_W+1)'(1);
        end
    end

    sequence s_rise_with_test;
        reset_rise && self_check_request;
    endsequence

    sequence s_rise_without_test;
        reset_rise && !self_check_request;
    endsequence

    sequence s_pin_high_twice;
        (!rst_i && ext_reset_n_i) ##1 (!rst_i && ext_reset_n_i);
    endsequence

    a_mode_self_check: assert property (@(posedge core_clk_i)
        disable iff (rst_i) s_rise_with_test |=> ##1 self_check_mode_o)
        else $error("self-check not entered");
    a_mode_held: assert property (@(posedge core_clk_i)
        disable iff (rst_i) (!reset_rise && !pin_in_reset)
        |=> $stable(mode))
        else $error("mode changed without reset edge");
    a_reset_pins_scm: assert property (@(posedge core_clk_i)
        disable iff (rst_i) pin_in_reset |=> single_chip_mode_o)
        else $error("pins not single-chip during reset");
    a_ports_input: assert property (@(posedge core_clk_i)
        disable iff (rst_i) pin_in_reset |=> first_port_dir_o == 8'h00
        && third_port_oe_o == 8'h00)
        else $error("ports not inputs in reset");
    a_display_default: assert property (@(posedge core_clk_i)
        disable iff (rst_i) pin_in_reset |=> &fourth_port_display_o
        && &fifth_port_display_o)
        else $error("display defaults lost");
    a_irq_open_drain: assert property (@(posedge core_clk_i)
        disable iff (rst_i) 1'b1 |-> !(third_port_oe_o[7]
        && third_port_out_o[7]) && !(third_port_oe_o[6]
        && third_port_out_o[6]))
        else $error("interrupt bit driven high");
    a_no_ext_bus: assert property (@(posedge core_clk_i)
        disable iff (rst_i) !external_bus_enable_o)
        else $error("external bus enabled");
    a_vector_sel: assert property (@(posedge core_clk_i)
        disable iff (rst_i) (self_check && !in_reset)
        |=> reset_vector_addr_o == SELF_CHECK_RESET_VECTOR)
        else $error("wrong reset vector");

    // Mode entry and reset pin checks
    a_single_entry: assert property (@(posedge core_clk_i)
        disable iff (rst_i) s_rise_without_test |=> ##1 single_chip_mode_o)
        else $error("single-chip not entered");
    a_mode_edge: assert property (@(posedge core_clk_i)
        disable iff (rst_i) $changed(mode)
        |-> $past(reset_rise) || $past(in_reset))
        else $error("mode changed off the reset edge");
    a_device_low: assert property (@(posedge core_clk_i)
        disable iff (rst_i) !ext_reset_n_i |-> ##2 device_reset_o)
        else $error("reset pin low not seen");
    a_reset_sync: assert property (@(posedge core_clk_i)
        disable iff (rst_i) s_pin_high_twice |=> !pin_in_reset)
        else $error("reset pin not synchronised");
    a_rise_single: assert property (@(posedge core_clk_i)
        disable iff (rst_i) reset_rise |=> !reset_rise)
        else $error("mode capture repeated");

    // Divider ratio, port and privilege checks
    a_div_ratio: assert property (@(posedge core_clk_i)
        disable iff (rst_i) (internal_op_tick_o && gap_valid
        && !select_changed && !in_reset) |-> tick_gap == ratio_expected)
        else $error("divider ratio wrong");
    a_key_wakeup: assert property (@(posedge core_clk_i)
        disable iff (rst_i) !in_reset
        |=> key_wakeup_input_o == $past(second_port_lines_i))
        else $error("key wakeup lines not passed");
    a_pullup_follow: assert property (@(posedge core_clk_i)
        disable iff (rst_i) !in_reset
        |=> second_port_pullup_o == $past(second_port_pullup_i))
        else $error("pull-up select not passed");
    a_serial_od: assert property (@(posedge core_clk_i)
        disable iff (rst_i) (!in_reset && (third_port_open_drain_i
        & SERIAL_SHARED_MASK) == SERIAL_SHARED_MASK)
        |=> (third_port_oe_o & third_port_out_o
        & SERIAL_SHARED_MASK) == 8'h00)
        else $error("serial bit driven high in open-drain");
    a_third_inputs: assert property (@(posedge core_clk_i)
        disable iff (rst_i) in_reset |=> third_port_oe_o == PORT_DIR_RESET)
        else $error("third port not inputs in reset");
    a_fifth_default: assert property (@(posedge core_clk_i)
        disable iff (rst_i) in_reset
        |=> fifth_port_display_o == FIFTH_DISPLAY_RESET)
        else $error("fifth port display default lost");
    a_pin_vector: assert property (@(posedge core_clk_i)
        disable iff (rst_i) pin_in_reset
        |=> reset_vector_addr_o == USER_RESET_VECTOR
        && !privileged_access_o)
        else $error("reset state not user mode");
    a_priv_locked: assert property (@(posedge core_clk_i)
        disable iff (rst_i) !self_check |=> !privileged_access_o)
        else $error("privileged bits open in user mode");
    a_priv_grant: assert property (@(posedge core_clk_i)
        disable iff (rst_i) (self_check && privileged_write_i && !in_reset)
        |=> privileged_access_o)
        else $error("privileged bits closed in self-check");
endmodule

//--- reset_mode_select_tb.sv
`timescale 1ns/10ps
module reset_mode_select_tb;
    import reset_mode_pkg::*;
    logic core_clk_i = 0, rst_i = 1, go = 0, mo = 1, so = 1, pw = 0;
    logic [1:0] strap = 2'h0, sel = 2'h0;
    logic [7:0] d1 = 8'hff, d3 = 8'hff, o3 = 8'hff, od = 8'hc7;
    logic [7:0] pu = 8'h5a, g5 = 8'hff, pb = 8'h3c;
    logic [6:0] g4 = 7'h7f;
    logic pin_n, tv, sl, tick, dr, single_chip_operating_mode, sch, xb, pa;
    logic [15:0] vec;
    logic [7:0] fd, oe, po, kw, pul, fifth;
    logic [6:0] fourth;
    int num_errors = 0, n_checks = 0;
    initial forever #20 core_clk_i = !core_clk_i;
    reset_strap_model u_reset_strap_model (.core_clk_i(core_clk_i),
        .rst_i(rst_i), .go_i(go), .strap_i(strap), .ext_reset_n_o(pin_n),
        .first_irq_test_voltage_o(tv), .second_irq_supply_level_o(sl));
    reset_mode_select u_reset_mode_select (.core_clk_i(core_clk_i),
        .rst_i(rst_i), .ext_reset_n_i(pin_n),
        .first_irq_test_voltage_i(tv), .second_irq_supply_level_i(sl),
        .main_osc_en_i(mo), .secondary_osc_en_i(so),
        .system_clock_select_field_i(sel), .first_port_dir_i(d1),
        .third_port_dir_i(d3), .third_port_out_i(o3),
        .third_port_open_drain_i(od), .second_port_pullup_i(pu),
        .fourth_port_gpo_sel_i(g4), .fifth_port_gpo_sel_i(g5),
        .second_port_lines_i(pb), .privileged_write_i(pw),
        .internal_op_tick_o(tick), .device_reset_o(dr),
        .self_check_mode_o(sch), .single_chip_mode_o(single_chip_operating_mode),
        .external_bus_enable_o(xb), .reset_vector_addr_o(vec),
        .privileged_access_o(pa), .first_port_dir_o(fd),
        .third_port_oe_o(oe), .third_port_out_o(po),
        .key_wakeup_input_o(kw), .second_port_pullup_o(pul),
        .fourth_port_display_o(fourth), .fifth_port_display_o(fifth));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        $display("Checks %0d, mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic pin_reset(input logic [1:0] s);
        @(posedge core_clk_i);
        go <= 1;
        strap <= s;
        @(posedge core_clk_i);
        go <= 0;
        repeat (3) @(posedge core_clk_i);
        #1;
        chk(16'(dr), 16'h1);
        chk(16'(fd), 16'(PORT_DIR_RESET));
        chk(16'(oe), 16'h0);
        chk(16'(fourth), 16'h7f);
        chk(16'(fifth), 16'hff);
        chk(16'(sch), 16'h0);
        repeat (20) @(posedge core_clk_i);
        #1;
    endtask
    task automatic t_defaults;
        chk(16'(fd), 16'h0);
        chk(16'(oe), 16'h0);
        chk(16'(fourth), 16'h7f);
        chk(16'(fifth), 16'hff);
        chk(16'({single_chip_operating_mode, sch, xb}), 16'h4);
        chk(vec, USER_RESET_VECTOR);
        $display("Test defaults done");
    endtask
    task automatic t_modes;
        @(posedge core_clk_i);
        pw <= 1;
        pin_reset(2'h2);
        chk(16'({single_chip_operating_mode, sch, pa}), 16'h4);
        pin_reset(2'h3);
        chk(16'({single_chip_operating_mode, sch, pa}), 16'h3);
        chk(vec, SELF_CHECK_RESET_VECTOR);
        chk(16'(kw), 16'h3c);
        chk(16'(pul), 16'h5a);
        repeat (30) @(posedge core_clk_i);
        #1;
        chk(16'({single_chip_operating_mode, sch}), 16'h1);
        pin_reset(2'h1);
        chk(16'({single_chip_operating_mode, sch, pa}), 16'h4);
        $display("Test modes done");
    endtask
    task automatic t_ports;
        @(posedge core_clk_i);
        d1 <= 8'hff;
        d3 <= 8'hff;
        o3 <= 8'hff;
        repeat (4) @(posedge core_clk_i);
        #1;
        chk(16'(oe & 8'hc0), 16'h0);
        chk(16'(oe & 8'h07), 16'h0);
        chk(16'(po), 16'hff);
        @(posedge core_clk_i);
        o3 <= 8'h00;
        g4 <= 7'h7f;
        repeat (4) @(posedge core_clk_i);
        #1;
        chk(16'(oe & 8'hc7), 16'hc7);
        chk(16'(fourth), 16'h0);
        $display("Test ports done");
    endtask
    task automatic t_div(input logic [1:0] s, input int cyc, input int exp);
        int n;
        n = 0;
        @(posedge core_clk_i);
        sel <= s;
        repeat (200) @(posedge core_clk_i);
        repeat (cyc)
        begin
            @(posedge core_clk_i);
            #1;
            if (tick === 1'b1)
                n++;
        end
        chk(16'(n), 16'(exp));
    endtask
    initial
    begin
        #200000;
        num_errors++;
        wrap_up();
    end
    initial
    begin
        repeat (2) @(posedge core_clk_i);
        rst_i <= 0;
        d1 <= 8'h00;
        d3 <= 8'h00;
        g4 <= 7'h00;
        @(posedge core_clk_i);
        #1;
        t_defaults();
        t_ports();
        t_modes();
        t_div(SYS_CLK_MAIN, 640, 10);
        t_div(SYS_CLK_SECONDARY, 64, 32);
        $display("Test divider done");
        wrap_up();
    end
endmodule

//--- reset_strap_model.sv
`timescale 1ns/10ps
// Board reset circuit and mode straps
module reset_strap_model
(
    // Clock and request
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic go_i,
    input wire logic [1:0] strap_i,
    // Reset pin and straps
    output logic ext_reset_n_o,
    output logic first_irq_test_voltage_o,
    output logic second_irq_supply_level_o
);
    logic [3:0] cnt;
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            cnt <= 4'h0;
        else if (go_i)
            cnt <= 4'hf;
        else if (cnt != 4'h0)
            cnt <= cnt - 4'h1;
    end
    // Pin low for four cycles
    assign ext_reset_n_o = !(cnt > 4'hb);
    // Straps stay put well past the pin rise
    assign first_irq_test_voltage_o = (cnt != 4'h0) && strap_i[1];
    assign second_irq_supply_level_o = (cnt != 4'h0) && strap_i[0];
endmodule
